//--- include/flash_guard_pkg.sv
// Overview of operation
// - Classify requests: debug, lower firmware, upper firmware
// - Debug may access unlocked pages
// - Debug refused on locked pages
// - Debug may always read lock bytes
// - Debug may always clear more lock bits
// - Unlocked security page erase resets locks
// - Locked security page needs full device erase
// - Reserved area always refused
// - Firmware ignores lock bytes
// - Lower firmware accesses all but erasing security page
// - Firmware never erases security page
// - Firmware may read and write security page
// - Upper firmware accesses pages at or above limit
// - Upper firmware refused below the limit
// - Fetches below the limit are allowed
// - Read wait setting in control bits 5-4
// - Control bits 3-1 read zero, write zero
// - Control bit 0 gates firmware writes, erases
// - Limit is register times 512, reset zero
// - Each lock bit guards one 16k block
// - Refused debug read returns no stored data
package flash_guard_pkg;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LIMIT_OFS = 8'h04;
  localparam logic [7:0] LOCK_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  // Control register fields and reset
  localparam int WAIT_LSB = 4;
  localparam int WREN_BIT = 0;
  localparam logic [7:0] CTRL_MASK = 8'h31;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [7:0] LOCK_ERASED = 8'hff;
  // Flash geometry
  localparam int ADDR_W = 17;
  localparam int LIMIT_SHIFT = 9;
  localparam int BLOCK_LSB = 14;
  localparam int PAGE_LSB = 10;
  localparam logic [6:0] SEC_PAGE = 7'h7e;
  localparam logic [6:0] RESV_PAGE = 7'h7f;
  localparam logic [16:0] WE_LOCK_ADDR = 17'h1fbfe;
  localparam logic [16:0] RD_LOCK_ADDR = 17'h1fbff;
  // Request source and operation
  typedef enum logic [1:0] {SRC_DEBUG, SRC_FW} src_t;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE, OP_FETCH} op_t;
  // Request from core or debug port
  typedef struct packed {
    logic valid;
    src_t src;
    op_t op;
    logic [16:0] pc;
    logic [16:0] addr;
    logic [7:0] wdata;
  } req_t;
  // Command toward the flash array
  typedef struct packed {
    logic write;
    logic erase;
    logic mass;
    logic [16:0] addr;
    logic [7:0] wdata;
  } flash_cmd_t;
  // Answer to the requester
  typedef struct packed {
    logic valid;
    logic granted;
    logic [7:0] rdata;
  } resp_t;
endpackage : flash_guard_pkg

//--- logic/flash_access_guard.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module flash_access_guard (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire flash_guard_pkg::req_t req, // Flash request
  input wire logic [7:0] flash_rdata, // Array data at req.addr
  output flash_guard_pkg::resp_t resp, // Decision and read data
  output flash_guard_pkg::flash_cmd_t cmd, // Command pulse to array
  output logic [1:0] read_wait // Read wait setting
);
  import flash_guard_pkg::*;

  logic [7:0] ctrl_q; // Control register
  logic [7:0] limit_q; // Access limit register
  logic [7:0] rd_lock_q; // Read lock byte copy
  logic [7:0] we_lock_q; // Write/erase lock byte copy
  logic [7:0] deny_cnt_q; // Refused request count
  logic [16:0] limit_addr; // Limit as byte address
  logic [2:0] blk; // 16k block of target
  logic sec_page; // Target in security page
  logic resv; // Target in reserved area
  logic lock_byte; // Target is a lock byte
  logic upper; // Firmware runs at or above limit
  logic area_ok; // Target reachable from caller
  logic wr_en; // Software write/erase enable
  logic grant_d; // Decision
  logic mass_d; // Full device erase
  logic setup; // APB setup phase
  logic [31:0] rd_mux; // Register read value
  logic mapped; // Address decodes

  assign limit_addr = {limit_q, {LIMIT_SHIFT{1'b0}}};
  assign blk = req.addr[16:BLOCK_LSB];
  assign sec_page = req.addr[16:PAGE_LSB] == SEC_PAGE;
  assign resv = req.addr[16:PAGE_LSB] == RESV_PAGE;
  assign lock_byte = (req.addr == WE_LOCK_ADDR) || (req.addr == RD_LOCK_ADDR);
  assign upper = req.pc >= limit_addr;
  assign area_ok = !upper || (req.addr >= limit_addr);
  assign wr_en = ctrl_q[WREN_BIT];
  assign setup = psel && !penable;

  // Permission decision per source
  always_comb begin
    grant_d = 1'b0;
    mass_d = 1'b0;
    if (resv) begin
      grant_d = 1'b0;
    end else if (req.src == SRC_DEBUG) begin
      case (req.op)
        OP_READ, OP_FETCH: begin
          // Lock bytes always readable
          grant_d = lock_byte || rd_lock_q[blk];
        end
        OP_WRITE: begin
          // Lock bytes always writable, bits only clear
          grant_d = lock_byte || we_lock_q[blk];
        end
        OP_ERASE: begin
          if (we_lock_q[blk]) begin
            grant_d = 1'b1;
          end else if (sec_page && lock_byte) begin
            grant_d = 1'b1;
            mass_d = 1'b1;
          end else begin
            grant_d = 1'b0;
          end
        end
        default: grant_d = 1'b0;
      endcase
    end else begin
      // Firmware: lock bytes play no part
      case (req.op)
        OP_FETCH: grant_d = 1'b1;
        OP_READ: grant_d = area_ok;
        OP_WRITE: grant_d = area_ok && wr_en;
        OP_ERASE: grant_d = area_ok && wr_en && !sec_page;
        default: grant_d = 1'b0;
      endcase
    end
  end

  // Answer to requester, one cycle after request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp <= '0;
    end else begin
      resp.valid <= req.valid;
      resp.granted <= req.valid && grant_d;
      // Refused or non-read gives zero data
      if (req.valid && grant_d && (req.op == OP_READ || req.op == OP_FETCH)) begin
        resp.rdata <= flash_rdata;
      end else begin
        resp.rdata <= 8'h00;
      end
    end
  end

  // Command pulse to the flash array
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '0;
    end else begin
      cmd.write <= req.valid && grant_d && req.op == OP_WRITE;
      cmd.erase <= req.valid && grant_d && req.op == OP_ERASE && !mass_d;
      cmd.mass <= req.valid && grant_d && mass_d;
      cmd.addr <= req.addr;
      cmd.wdata <= req.wdata;
    end
  end

  // Lock byte copies follow granted writes and erases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_lock_q <= LOCK_ERASED;
      we_lock_q <= LOCK_ERASED;
    end else if (req.valid && grant_d) begin
      if (req.op == OP_ERASE && (sec_page || mass_d)) begin
        // Erased security page unlocks everything
        rd_lock_q <= LOCK_ERASED;
        we_lock_q <= LOCK_ERASED;
      end else if (req.op == OP_WRITE && req.addr == RD_LOCK_ADDR) begin
        rd_lock_q <= rd_lock_q & req.wdata;
      end else if (req.op == OP_WRITE && req.addr == WE_LOCK_ADDR) begin
        we_lock_q <= we_lock_q & req.wdata;
      end
    end
  end

  // Refused request counter, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deny_cnt_q <= 8'h00;
    end else if (req.valid && !grant_d && deny_cnt_q != 8'hff) begin
      deny_cnt_q <= deny_cnt_q + 8'h01;
    end
  end

  // Control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == CTRL_OFS) begin
      // Reserved bits held at zero
      ctrl_q <= pwdata[7:0] & CTRL_MASK;
    end
  end

  // Access limit register, cleared by full erase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_q <= LIMIT_RESET;
    end else if (cmd.mass) begin
      limit_q <= LIMIT_RESET;
    end else if (psel && penable && pwrite && paddr == LIMIT_OFS) begin
      limit_q <= pwdata[7:0];
    end
  end

  // Register read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      CTRL_OFS: rd_mux = {24'h000000, ctrl_q};
      LIMIT_OFS: rd_mux = {24'h000000, limit_q};
      LOCK_OFS: rd_mux = {16'h0000, rd_lock_q, we_lock_q};
      STATUS_OFS: rd_mux = {24'h000000, deny_cnt_q};
      default: mapped = 1'b0;
    endcase
  end

  // APB answer, ready in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Wait setting to the flash timing logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_wait <= CTRL_RESET[WAIT_LSB +: 2];
    end else begin
      read_wait <= ctrl_q[WAIT_LSB +: 2];
    end
  end

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Reserved area is always refused
  AST_RESV_DENY: assert property (req.valid && resv |=> resp.valid && !resp.granted)
    else $error("reserved area granted");

  // Locked debug read refused
  AST_DBG_LOCKED_READ: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_READ && !lock_byte && !resv
    && !rd_lock_q[blk] |=> !resp.granted && resp.rdata == 8'h00)
    else $error("locked debug read granted");

  // Lock bytes always readable by debug
  AST_LOCK_BYTE_READ: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_READ && lock_byte
    |=> resp.granted)
    else $error("lock byte read refused");

  // Firmware never erases security page
  AST_FW_SEC_ERASE: assert property (
    req.valid && req.src == SRC_FW && req.op == OP_ERASE && sec_page
    |=> !resp.granted && !cmd.erase && !cmd.mass)
    else $error("firmware erased security page");

  // Upper firmware refused below limit
  AST_UPPER_BELOW: assert property (
    req.valid && req.src == SRC_FW && req.op != OP_FETCH && upper
    && req.addr < limit_addr |=> !resp.granted)
    else $error("upper firmware reached lower partition");

  // Firmware writes need enable bit
  AST_WREN_GATE: assert property (
    req.valid && req.src == SRC_FW && !wr_en |=> !cmd.write && !cmd.erase)
    else $error("write without enable");

  // Refused answer carries no data
  AST_DENY_NO_DATA: assert property (resp.valid && !resp.granted |-> resp.rdata == 8'h00)
    else $error("refused read exposed data");

  // Full erase leaves locks erased, limit cleared one cycle on
  AST_MASS_UNLOCK: assert property (
    cmd.mass |-> (we_lock_q == LOCK_ERASED && rd_lock_q == LOCK_ERASED)
    ##1 limit_q == LIMIT_RESET)
    else $error("full erase left locks");

  // Fetch by firmware allowed everywhere outside the reserved area
  AST_FETCH_OK: assert property (
    req.valid && req.src == SRC_FW && req.op == OP_FETCH && !resv |=> resp.granted)
    else $error("fetch refused");

  // Reserved control bits read zero
  AST_CTRL_RSV: assert property (
    setup && !pwrite && paddr == CTRL_OFS |=> pready && prdata[3:1] == 3'b000)
    else $error("reserved control bits nonzero");

  // Lock bits only rise by erase
  AST_LOCK_ONLY_CLEAR: assert property (
    (we_lock_q & ~$past(we_lock_q)) != 8'h00 |-> cmd.erase || cmd.mass)
    else $error("lock bit rose without erase");

  // Unlocked block readable by debug, stored data passed through
  AST_DBG_OPEN_READ: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_READ && !resv && rd_lock_q[blk]
    |=> resp.granted && resp.rdata == $past(flash_rdata))
    else $error("open debug read refused");

  // Locked block keeps debug writes out
  AST_DBG_LOCKED_WRITE: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_WRITE && !lock_byte
    && !we_lock_q[blk] |=> !resp.granted && !cmd.write)
    else $error("locked debug write granted");

  // Unlocked block erased by debug as a single page
  AST_DBG_OPEN_ERASE: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_ERASE && !resv && we_lock_q[blk]
    |=> cmd.erase && !cmd.mass)
    else $error("open debug erase refused");

  // Debug writes to lock bytes always reach the array
  AST_LOCK_BYTE_WRITE: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_WRITE && lock_byte
    |=> resp.granted && cmd.write)
    else $error("lock byte write refused");

  // Lock write can only clear bits, never set them
  AST_LOCK_AND: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_WRITE && req.addr == RD_LOCK_ADDR
    |=> rd_lock_q == ($past(rd_lock_q) & $past(req.wdata)))
    else $error("lock write set a bit");

  // Erasing an open security page drops every lock
  AST_SEC_ERASE_RESET: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_ERASE && sec_page && we_lock_q[blk]
    |=> cmd.erase && we_lock_q == LOCK_ERASED && rd_lock_q == LOCK_ERASED)
    else $error("security page erase kept locks");

  // Locked security page cannot be erased directly
  AST_SEC_ERASE_LOCKED: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_ERASE && sec_page && !lock_byte
    && !we_lock_q[blk] |=> !resp.granted && !cmd.erase && !cmd.mass)
    else $error("locked security page erased");

  // Erase aimed at a lock byte of a locked page is a full erase
  AST_MASS_FROM_LOCK: assert property (
    req.valid && req.src == SRC_DEBUG && req.op == OP_ERASE && lock_byte
    && !we_lock_q[blk] |=> cmd.mass && !cmd.erase)
    else $error("full erase not started");

  // Firmware can never start a full erase
  AST_MASS_DEBUG_ONLY: assert property (
    req.valid && req.src == SRC_FW
    |=> !cmd.mass)
    else $error("firmware started full erase");

  // Reserved area never reaches the array
  AST_RESV_NO_CMD: assert property (
    req.valid && resv
    |=> !cmd.write && !cmd.erase && !cmd.mass && resp.rdata == 8'h00)
    else $error("reserved area reached array");

  // Lower firmware reads whatever the lock bytes say
  AST_FW_NO_LOCKS: assert property (
    req.valid && req.src == SRC_FW && req.op == OP_READ && !resv && !upper
    |=> resp.granted)
    else $error("lower firmware read refused");

  // Lower firmware erases ordinary pages when enabled
  AST_LOWER_ERASE: assert property (
    req.valid && req.src == SRC_FW && req.op == OP_ERASE && !resv && !sec_page && !upper
    && wr_en |=> cmd.erase)
    else $error("lower firmware erase refused");

  // Firmware may write the security page to lock more blocks
  AST_FW_SEC_WRITE: assert property (
    req.valid && req.src == SRC_FW && req.op == OP_WRITE && sec_page && wr_en
    && req.addr >= limit_addr |=> resp.granted && cmd.write)
    else $error("firmware security page write refused");

  // Upper firmware writes its own partition
  AST_UPPER_ABOVE: assert property (
    req.valid && req.src == SRC_FW && req.op == OP_WRITE && !resv && upper && wr_en
    && req.addr >= limit_addr |=> cmd.write)
    else $error("upper firmware write refused");

  // Upper firmware may still branch into the lower partition
  AST_UPPER_FETCH_BELOW: assert property (
    req.valid && req.src == SRC_FW && req.op == OP_FETCH && !resv && upper
    && req.addr < limit_addr |=> resp.granted)
    else $error("branch below limit refused");

  // Wait output trails the control field by one cycle
  AST_READ_WAIT: assert property (
    read_wait == $past(ctrl_q[WAIT_LSB +: 2])
    )
    else $error("read wait not following control");

  // Control write keeps reserved bits clear and loads the enable
  AST_CTRL_WRITE: assert property (
    psel && penable && pwrite && paddr == CTRL_OFS
    |=> ctrl_q[3:1] == 3'b000 && ctrl_q[WREN_BIT] == $past(pwdata[WREN_BIT]))
    else $error("control write mishandled");

  // Limit write loads the eight upper address bits
  AST_LIMIT_WRITE: assert property (
    psel && penable && pwrite && paddr == LIMIT_OFS && !cmd.mass
    |=> limit_q == $past(pwdata[7:0]))
    else $error("limit write lost");

  // Ready follows each setup cycle with no wait states
  AST_APB_READY: assert property (
    pready == $past(setup)
    )
    else $error("ready out of step with setup");

  COV_DBG_SEC_ERASE: cover property (cmd.erase && cmd.addr[16:PAGE_LSB] == SEC_PAGE);
  COV_MASS_ERASE: cover property (cmd.mass);
  COV_UPPER_DENY: cover property (req.valid && req.src == SRC_FW && upper && !area_ok);
  COV_APB_ERR: cover property (pready && pslverr);
  COV_FW_LOCK_WRITE: cover property (cmd.write && cmd.addr == WE_LOCK_ADDR);
endmodule : flash_access_guard
`default_nettype wire

//--- verification/flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  input wire flash_guard_pkg::req_t req, // Request seen by the array
  output logic [7:0] flash_rdata // Stored byte at req.addr
);
  import flash_guard_pkg::*;
  // Array contents follow the address, so a leak of stored data is visible
  assign flash_rdata = req.addr[7:0] ^ 8'h5a;
endmodule : flash_model
`default_nettype wire

//--- verification/test_flash_access_guard.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module test_flash_access_guard;
  import flash_guard_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // Bus inputs
  logic [7:0] paddr = 8'h00; // Bus address
  logic [31:0] pwdata = 32'h0, prdata, rd; // Bus data and last read
  logic pready, pslverr, er; // Bus answer and last error
  req_t req = '0; // Flash request
  logic [7:0] flash_rdata; // Array byte
  resp_t resp; // Decision
  flash_cmd_t cmd; // Array command
  logic [1:0] read_wait; // Wait setting
  int err_total = 0, n_tests = 0, n_deny = 0; // Counters
  // 50 MHz clock
  always #10 pclk = ~pclk;
  flash_access_guard u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .flash_rdata(flash_rdata), .resp(resp), .cmd(cmd),
    .read_wait(read_wait));
  flash_model u_flash (.req(req), .flash_rdata(flash_rdata));
  // Counts and verdict
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken at the rising edge where pready is high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One flash request and its judged answer
  task automatic fl(input src_t s, input op_t o, input logic [16:0] pc, input logic [16:0] a,
    input logic [7:0] d, input logic g);
    @(posedge pclk);
    req <= '{1'b1, s, o, pc, a, d};
    @(posedge pclk);
    req.valid <= 1'b0;
    #1;
    `CHK(resp.valid, 1'b1)
    `CHK(resp.granted, g)
    `CHK(resp.rdata, (g && (o == OP_READ || o == OP_FETCH)) ? (a[7:0] ^ 8'h5a) : 8'h00)
    `CHK(cmd.write, g && o == OP_WRITE)
    `CHK(cmd.erase | cmd.mass, g && o == OP_ERASE)
    `CHK(cmd.addr, a)
    `CHK(cmd.wdata, d)
    if (!g) n_deny++;
  endtask : fl
  // Register reset values, masking and the wait field
  task automatic t_regs();
    `CHK(read_wait, CTRL_RESET[WAIT_LSB +: 2])
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rd, {24'h000000, CTRL_RESET})
    `CHK(er, 1'b0)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b0, LIMIT_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, LOCK_OFS, 32'h0);
    `CHK(rd, 32'h0000ffff)
    apb(1'b1, 8'h10, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, CTRL_OFS, 32'hff);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rd, 32'h31)
    `CHK(read_wait, 2'b11)
    apb(1'b1, CTRL_OFS, 32'h10);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(read_wait, 2'b01)
    $display("test regs done");
  endtask : t_regs
  // Firmware writes gated by the enable bit
  task automatic t_wren();
    fl(SRC_FW, OP_WRITE, 17'h0, 17'h00100, 8'h12, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h11);
    fl(SRC_FW, OP_WRITE, 17'h0, 17'h00100, 8'h12, 1'b1);
    $display("test wren done");
  endtask : t_wren
  // Debug port against lock bytes and the reserved area
  task automatic t_debug();
    fl(SRC_DEBUG, OP_READ, 17'h0, 17'h00200, 8'h00, 1'b1);
    fl(SRC_DEBUG, OP_READ, 17'h0, 17'h1fc10, 8'h00, 1'b0);
    fl(SRC_FW, OP_WRITE, 17'h0, 17'h1fc10, 8'h00, 1'b0);
    fl(SRC_DEBUG, OP_WRITE, 17'h0, WE_LOCK_ADDR, 8'h7f, 1'b1);
    apb(1'b0, LOCK_OFS, 32'h0);
    `CHK(rd, 32'h0000ff7f)
    fl(SRC_DEBUG, OP_WRITE, 17'h0, 17'h1c000, 8'h00, 1'b0);
    fl(SRC_DEBUG, OP_READ, 17'h0, RD_LOCK_ADDR, 8'h00, 1'b1);
    fl(SRC_FW, OP_READ, 17'h0, 17'h1c000, 8'h00, 1'b1);
    fl(SRC_DEBUG, OP_ERASE, 17'h0, 17'h1f800, 8'h00, 1'b0);
    fl(SRC_DEBUG, OP_ERASE, 17'h0, WE_LOCK_ADDR, 8'h00, 1'b1);
    `CHK(cmd.mass, 1'b1)
    apb(1'b0, LOCK_OFS, 32'h0);
    `CHK(rd, 32'h0000ffff)
    fl(SRC_DEBUG, OP_WRITE, 17'h0, RD_LOCK_ADDR, 8'hfe, 1'b1);
    fl(SRC_DEBUG, OP_READ, 17'h0, 17'h00200, 8'h00, 1'b0);
    fl(SRC_DEBUG, OP_ERASE, 17'h0, 17'h1f800, 8'h00, 1'b1);
    `CHK(cmd.mass, 1'b0)
    apb(1'b0, LOCK_OFS, 32'h0);
    `CHK(rd, 32'h0000ffff)
    $display("test debug done");
  endtask : t_debug
  // Partitions around the access limit at 0x02000
  task automatic t_limit();
    apb(1'b1, LIMIT_OFS, 32'h10);
    fl(SRC_FW, OP_READ, 17'h04000, 17'h01000, 8'h00, 1'b0);
    fl(SRC_FW, OP_WRITE, 17'h04000, 17'h04400, 8'h33, 1'b1);
    fl(SRC_FW, OP_FETCH, 17'h04000, 17'h01000, 8'h00, 1'b1);
    fl(SRC_FW, OP_READ, 17'h00000, 17'h01000, 8'h00, 1'b1);
    fl(SRC_FW, OP_ERASE, 17'h00000, 17'h00400, 8'h00, 1'b1);
    fl(SRC_FW, OP_ERASE, 17'h00000, 17'h1f800, 8'h00, 1'b0);
    fl(SRC_FW, OP_ERASE, 17'h04000, 17'h1f800, 8'h00, 1'b0);
    fl(SRC_FW, OP_WRITE, 17'h04000, WE_LOCK_ADDR, 8'hfe, 1'b1);
    apb(1'b0, LOCK_OFS, 32'h0);
    `CHK(rd, 32'h0000fffe)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd, 32'(n_deny))
    $display("test limit done");
  endtask : t_limit
  // Reset in mid-run returns every register to its reset value
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK({resp.valid, cmd.write, cmd.erase, cmd.mass, read_wait}, 6'h00)
    presetn <= 1'b1;
    apb(1'b0, LOCK_OFS, 32'h0);
    `CHK(rd, {16'h0000, LOCK_ERASED, LOCK_ERASED})
    apb(1'b0, LIMIT_OFS, 32'h0);
    `CHK(rd, {24'h000000, LIMIT_RESET})
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rd, {24'h000000, CTRL_RESET})
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd, 32'h0)
    fl(SRC_FW, OP_WRITE, 17'h0, 17'h00100, 8'h12, 1'b0);
    $display("test reset done");
  endtask : t_reset
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_wren();
    t_debug();
    t_limit();
    t_reset();
    finish_test();
  end
endmodule : test_flash_access_guard
`default_nettype wire
